// *** core/crf_defs.vh ***
// constants for the cpu register file and condition code block
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH
`define CRF_CCR_I 7
`define CRF_CCR_UI 6
`define CRF_CCR_H 5
`define CRF_CCR_U 4
`define CRF_CCR_N 3
`define CRF_CCR_Z 2
`define CRF_CCR_V 1
`define CRF_CCR_C 0
`define CRF_CCR_RST 8'h80
`define CRF_PC_RST 24'h000000
`define CRF_SP_IDX 3'h7
`define CRF_ADDR20_MASK 24'h0FFFFF
`define CRF_SZ_B 2'h0
`define CRF_SZ_W 2'h1
`define CRF_SZ_L 2'h2
`define CRF_OP_NONE 3'h0
`define CRF_OP_ADD 3'h1
`define CRF_OP_SUB 3'h2
`define CRF_OP_LOGIC 3'h3
`define CRF_OP_SHIFT 3'h4
`define CRF_OP_MOVE 3'h5
`define CRF_CC_AND 2'h0
`define CRF_CC_OR 2'h1
`define CRF_CC_XOR 2'h2
`define CRF_CC_LOAD 2'h3
`endif

// *** core/crf_flag_calc.v ***
// flag computation for arithmetic, logic and shift results
`timescale 1ns/1ps
`include "crf_defs.vh"
module crf_flag_calc (
  input wire [2:0] op,
  input wire [1:0] size,
  input wire [31:0] opa,
  input wire [31:0] opb,
  input wire carry_in,
  input wire shift_out,
  input wire [31:0] result,
  output reg flag_h,
  output reg flag_n,
  output reg flag_z,
  output reg flag_v,
  output reg flag_c
);
  reg [32:0] full;
  reg [28:0] part;
  reg sa;
  reg sb;
  reg sr;
  reg [31:0] res_m;
  // size dependent half carry, sign and zero
  always @*
  begin
    full = 33'h000000000;
    part = 29'h00000000;
    res_m = result;
    sa = opa[31];
    sb = opb[31];
    sr = result[31];
    flag_h = 1'b0;
    flag_v = 1'b0;
    flag_c = 1'b0;
    case (size)
      `CRF_SZ_B:
      begin
        res_m = {24'h000000, result[7:0]};
        sa = opa[7];
        sb = opb[7];
        sr = result[7];
      end
      `CRF_SZ_W:
      begin
        res_m = {16'h0000, result[15:0]};
        sa = opa[15];
        sb = opb[15];
        sr = result[15];
      end
      default:
      begin
        res_m = result;
      end
    endcase
    flag_n = sr;
    flag_z = (res_m == 32'h00000000);
    case (op)
      `CRF_OP_ADD:
      begin
        // carry into bit 4/12/28 is the half carry
        case (size)
          `CRF_SZ_B: part = {25'h0, opa[3:0]} + {25'h0, opb[3:0]} + {28'h0, carry_in};
          `CRF_SZ_W: part = {17'h0, opa[11:0]} + {17'h0, opb[11:0]} + {28'h0, carry_in};
          default: part = {1'b0, opa[27:0]} + {1'b0, opb[27:0]} + {28'h0, carry_in};
        endcase
        case (size)
          `CRF_SZ_B: full = {25'h0, opa[7:0]} + {25'h0, opb[7:0]} + {32'h0, carry_in};
          `CRF_SZ_W: full = {17'h0, opa[15:0]} + {17'h0, opb[15:0]} + {32'h0, carry_in};
          default: full = {1'b0, opa} + {1'b0, opb} + {32'h0, carry_in};
        endcase
        flag_h = (size == `CRF_SZ_B) ? part[4] : (size == `CRF_SZ_W) ? part[12] : part[28];
        flag_c = (size == `CRF_SZ_B) ? full[8] : (size == `CRF_SZ_W) ? full[16] : full[32];
        flag_v = (sa == sb) && (sr != sa);
      end
      `CRF_OP_SUB:
      begin
        // borrow out of bit 3/11/27 and out of the top bit
        case (size)
          `CRF_SZ_B: part = {25'h0, opa[3:0]} - {25'h0, opb[3:0]} - {28'h0, carry_in};
          `CRF_SZ_W: part = {17'h0, opa[11:0]} - {17'h0, opb[11:0]} - {28'h0, carry_in};
          default: part = {1'b0, opa[27:0]} - {1'b0, opb[27:0]} - {28'h0, carry_in};
        endcase
        case (size)
          `CRF_SZ_B: full = {25'h0, opa[7:0]} - {25'h0, opb[7:0]} - {32'h0, carry_in};
          `CRF_SZ_W: full = {17'h0, opa[15:0]} - {17'h0, opb[15:0]} - {32'h0, carry_in};
          default: full = {1'b0, opa} - {1'b0, opb} - {32'h0, carry_in};
        endcase
        flag_h = (size == `CRF_SZ_B) ? part[4] : (size == `CRF_SZ_W) ? part[12] : part[28];
        flag_c = (size == `CRF_SZ_B) ? full[8] : (size == `CRF_SZ_W) ? full[16] : full[32];
        flag_v = (sa != sb) && (sr != sa);
      end
      `CRF_OP_SHIFT:
      begin
        flag_c = shift_out;
        flag_v = 1'b0;
      end
      default:
      begin
        flag_v = 1'b0; // logic and move clear overflow
      end
    endcase
  end
endmodule

// *** core/crf_core.v ***
// cpu general registers, program counter and condition code register
// Behaviour
// - eight identical 32-bit general registers, data or address use alike
// - each register splits into extended upper and lower 16-bit halves
// - lower half splits into separately accessible high and low bytes
// - eighth register is the stack pointer, used in exceptions and calls
// - 24-bit program counter holds next instruction address
// - instruction fetch address forces program counter bit 0 to zero
// - 8-bit condition code register, bit 7 mask down to bit 0 carry
// - mask bit blocks all interrupts except the non-maskable one
// - exception start sets the interrupt mask bit
// - bit 6 acts as extra interrupt mask and user storage
// - bits 6 and 4 readable and writable via flag instructions
// - half carry from bit 3, 11 or 27 on add, sub, compare, negate
// - negative flag takes the result sign bit
// - zero flag set on zero result, cleared otherwise
// - overflow set on arithmetic overflow, cleared otherwise
// - carry holds add carry, subtract borrow, or shifted-out bit
// - bit manipulation uses carry as one-bit accumulator
// - branch conditions from N Z V C; flags may stay; whole register ops
// - reset clears pc to 24'h000000 (vector_value unused), sets mask; other state uninitialised
// - 1-Mbyte modes mask effective addresses to 20 bits
// - advanced mode only, 16-Mbyte linear space
`timescale 1ns/1ps
`include "crf_defs.vh"
module crf_core (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  // register write port
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [1:0] wr_size,
  input wire wr_upper,
  input wire wr_high_byte,
  input wire [31:0] wr_data,
  // register read ports
  input wire [2:0] rd_a_idx,
  input wire [2:0] rd_b_idx,
  output wire [31:0] rd_a_data,
  output wire [31:0] rd_b_data,
  output wire [31:0] stack_pointer_register,
  // stack pointer update during exceptions and calls
  input wire sp_wr_en,
  input wire [31:0] sp_wr_data,
  // program counter
  input wire pc_load,
  input wire [23:0] pc_load_value,
  input wire pc_advance,
  input wire [23:0] vector_value,
  output wire [23:0] pc_value,
  output wire [23:0] fetch_addr,
  // effective address masking
  input wire mode_1mbyte,
  input wire [23:0] eff_addr_in,
  output wire [23:0] eff_addr_out,
  // flag update from the datapath
  input wire flag_update,
  input wire [2:0] flag_op,
  input wire [1:0] flag_size,
  input wire [31:0] flag_opa,
  input wire [31:0] flag_opb,
  input wire flag_carry_in,
  input wire flag_shift_out,
  input wire [31:0] flag_result,
  input wire [7:0] flag_keep,
  // bit accumulator
  input wire bit_acc_wr,
  input wire bit_acc_value,
  output wire bit_acc,
  // whole condition code register operations
  input wire ccr_op_en,
  input wire [1:0] ccr_op,
  input wire [7:0] ccr_operand,
  output wire [7:0] condition_code_register,
  // exceptions and interrupts
  input wire exc_start,
  input wire irq_req,
  input wire nmi_req,
  output wire irq_accept,
  output wire nmi_accept,
  output wire ui_mask,
  // branch condition evaluation
  input wire [3:0] branch_cond,
  output reg branch_taken
);
  wire [31:0] wide_general_register [0:7];
  reg [23:0] pc_q;
  wire [7:0] ccr_q;
  reg ccr_i_q;
  reg [6:0] ccr_lo_q;
  reg [7:0] ccr_d;
  wire flag_h;
  wire flag_n;
  wire flag_z;
  wire flag_v;
  wire flag_c;
  reg [7:0] calc_ccr;

  crf_flag_calc u_flag (
    .op(flag_op),
    .size(flag_size),
    .opa(flag_opa),
    .opb(flag_opb),
    .carry_in(flag_carry_in),
    .shift_out(flag_shift_out),
    .result(flag_result),
    .flag_h(flag_h),
    .flag_n(flag_n),
    .flag_z(flag_z),
    .flag_v(flag_v),
    .flag_c(flag_c)
  );

  // general registers have no reset value; one generate entry per register
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_reg
      wire hit;
      wire sp_hit;
      reg [31:0] value_q;
      assign hit = wr_en && (wr_idx == gi); // all eight alike
      assign sp_hit = sp_wr_en && (gi == `CRF_SP_IDX); // implicit stack use
      always @(posedge clk_sys)
      begin
        if (clk_en)
        begin
          if (sp_hit)
            value_q <= sp_wr_data;
          else if (hit)
          begin
            case (wr_size)
              `CRF_SZ_L: value_q <= wr_data;
              `CRF_SZ_W:
              begin
                // only the chosen half changes
                if (wr_upper)
                  value_q[31:16] <= wr_data[15:0];
                else
                  value_q[15:0] <= wr_data[15:0];
              end
              default:
              begin
                // only the chosen byte changes
                if (wr_high_byte)
                  value_q[15:8] <= wr_data[7:0];
                else
                  value_q[7:0] <= wr_data[7:0];
              end
            endcase
          end
        end
      end
      // each entry has its own single driver
      assign wide_general_register[gi] = value_q;
    end
  endgenerate

  assign rd_a_data = wide_general_register[rd_a_idx];
  assign rd_b_data = wide_general_register[rd_b_idx];
  assign stack_pointer_register = wide_general_register[`CRF_SP_IDX];

  // program counter, cleared to 24'h000000 at reset, vector_value unused
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pc_q <= `CRF_PC_RST;
    else if (clk_en)
    begin
      if (exc_start && !pc_load)
        pc_q <= pc_q;
      if (pc_load)
        pc_q <= pc_load_value; // vector or jump target
      else if (pc_advance)
        pc_q <= pc_q + 24'h000002; // one word per step
    end
  end

  assign pc_value = pc_q;
  assign fetch_addr = {pc_q[23:1], 1'b0};
  assign eff_addr_out = mode_1mbyte ? (eff_addr_in & `CRF_ADDR20_MASK) : eff_addr_in;

  // flags from datapath, keeping bits the instruction leaves alone
  always @*
  begin
    calc_ccr = ccr_q;
    calc_ccr[`CRF_CCR_H] = flag_h;
    calc_ccr[`CRF_CCR_N] = flag_n;
    calc_ccr[`CRF_CCR_Z] = flag_z;
    calc_ccr[`CRF_CCR_V] = flag_v;
    calc_ccr[`CRF_CCR_C] = flag_c;
    calc_ccr = (calc_ccr & ~flag_keep) | (ccr_q & flag_keep);
    calc_ccr[`CRF_CCR_I] = ccr_q[`CRF_CCR_I];
    calc_ccr[`CRF_CCR_UI] = ccr_q[`CRF_CCR_UI];
    calc_ccr[`CRF_CCR_U] = ccr_q[`CRF_CCR_U];
  end

  // next condition code value; exception start sets the mask bit over all others, other bits still update
  always @*
  begin
    ccr_d = ccr_q;
    if (ccr_op_en)
    begin
      case (ccr_op)
        `CRF_CC_AND: ccr_d = ccr_q & ccr_operand;
        `CRF_CC_OR: ccr_d = ccr_q | ccr_operand;
        `CRF_CC_XOR: ccr_d = ccr_q ^ ccr_operand;
        default: ccr_d = ccr_operand; // load
      endcase
    end
    else if (flag_update)
      ccr_d = calc_ccr;
    if (bit_acc_wr)
      ccr_d[`CRF_CCR_C] = bit_acc_value;
    if (exc_start)
      ccr_d[`CRF_CCR_I] = 1'b1;
  end

  // only the mask bit has a reset value; others left as found at reset
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ccr_i_q <= 1'b1;
    else if (clk_en)
      ccr_i_q <= ccr_d[`CRF_CCR_I];
  end

  // remaining flag bits have no reset
  always @(posedge clk_sys)
  begin
    if (clk_en)
      ccr_lo_q <= ccr_d[6:0];
  end

  // whole register view of the two flop groups
  assign ccr_q = {ccr_i_q, ccr_lo_q};

  assign condition_code_register = ccr_q;
  assign bit_acc = ccr_q[`CRF_CCR_C];
  assign ui_mask = ccr_q[`CRF_CCR_UI];
  assign irq_accept = irq_req && !ccr_q[`CRF_CCR_I];
  assign nmi_accept = nmi_req;

  // conventional branch condition codes over N Z V C
  always @*
  begin
    case (branch_cond)
      4'h0: branch_taken = 1'b1;
      4'h1: branch_taken = 1'b0;
      4'h2: branch_taken = !(ccr_q[`CRF_CCR_C] | ccr_q[`CRF_CCR_Z]);
      4'h3: branch_taken = ccr_q[`CRF_CCR_C] | ccr_q[`CRF_CCR_Z];
      4'h4: branch_taken = !ccr_q[`CRF_CCR_C];
      4'h5: branch_taken = ccr_q[`CRF_CCR_C];
      4'h6: branch_taken = !ccr_q[`CRF_CCR_Z];
      4'h7: branch_taken = ccr_q[`CRF_CCR_Z];
      4'h8: branch_taken = !ccr_q[`CRF_CCR_V];
      4'h9: branch_taken = ccr_q[`CRF_CCR_V];
      4'hA: branch_taken = !ccr_q[`CRF_CCR_N];
      4'hB: branch_taken = ccr_q[`CRF_CCR_N];
      4'hC: branch_taken = !(ccr_q[`CRF_CCR_N] ^ ccr_q[`CRF_CCR_V]);
      4'hD: branch_taken = ccr_q[`CRF_CCR_N] ^ ccr_q[`CRF_CCR_V];
      4'hE: branch_taken = !(ccr_q[`CRF_CCR_Z] | (ccr_q[`CRF_CCR_N] ^ ccr_q[`CRF_CCR_V]));
      default: branch_taken = ccr_q[`CRF_CCR_Z] | (ccr_q[`CRF_CCR_N] ^ ccr_q[`CRF_CCR_V]);
    endcase
  end
endmodule

// *** tb/crf_core_monitor.sv ***
// assertion checker for the register file block
`timescale 1ns/1ps
module crf_core_monitor (
  input wire clk_sys,
  input wire rst_n,
  input wire clk_en,
  input wire [31:0] stack_pointer_register,
  input wire sp_wr_en,
  input wire [31:0] sp_wr_data,
  input wire pc_load,
  input wire [23:0] pc_load_value,
  input wire pc_advance,
  input wire [23:0] pc_value,
  input wire [23:0] fetch_addr,
  input wire mode_1mbyte,
  input wire [23:0] eff_addr_in,
  input wire [23:0] eff_addr_out,
  input wire bit_acc_wr,
  input wire bit_acc_value,
  input wire bit_acc,
  input wire [7:0] condition_code_register,
  input wire exc_start,
  input wire irq_req,
  input wire nmi_req,
  input wire irq_accept,
  input wire nmi_accept,
  input wire ui_mask
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // address, pc and stack pointer relations
  property p_fetch; fetch_addr == {pc_value[23:1], 1'h0}; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address odd");
  property p_ea; eff_addr_out == (mode_1mbyte ? {4'h0, eff_addr_in[19:0]} : eff_addr_in);
  endproperty
  a_ea: assert property (p_ea) else $error("address mask wrong");
  property p_pcadv; clk_en && pc_advance && !pc_load |=> pc_value == $past(pc_value) + 24'h2;
  endproperty
  a_pcadv: assert property (p_pcadv) else $error("pc step wrong");
  property p_pcld; clk_en && pc_load |=> pc_value == $past(pc_load_value); endproperty
  a_pcld: assert property (p_pcld) else $error("pc load lost");
  property p_sp; clk_en && sp_wr_en |=> stack_pointer_register == $past(sp_wr_data); endproperty
  a_sp: assert property (p_sp) else $error("stack pointer write lost");
  // interrupt masking and flag bits
  property p_irq; irq_accept == (irq_req && !condition_code_register[7]); endproperty
  a_irq: assert property (p_irq) else $error("mask not applied");
  property p_nmi; nmi_req |-> nmi_accept; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi refused");
  property p_exc; clk_en && exc_start |=> condition_code_register[7]; endproperty
  a_exc: assert property (p_exc) else $error("mask not set on exception");
  property p_ui; condition_code_register[6] |-> ui_mask; endproperty
  a_ui: assert property (p_ui) else $error("user mask bit not shown");
  property p_ui_clr; !condition_code_register[6] |-> !ui_mask; endproperty
  a_ui_clr: assert property (p_ui_clr) else $error("user mask shown while clear");
  property p_bacc; clk_en && bit_acc_wr && !exc_start |=> bit_acc == $past(bit_acc_value);
  endproperty
  a_bacc: assert property (p_bacc) else $error("bit accumulator lost");
  // main scenarios reached
  c_exc: cover property (clk_en && exc_start);
  c_irq: cover property (irq_accept);
  c_ea: cover property (mode_1mbyte);
endmodule
bind crf_core crf_core_monitor u_mon (.clk_sys, .rst_n, .clk_en, .stack_pointer_register,
  .sp_wr_en, .sp_wr_data, .pc_load, .pc_load_value, .pc_advance, .pc_value, .fetch_addr,
  .mode_1mbyte, .eff_addr_in, .eff_addr_out, .bit_acc_wr, .bit_acc_value, .bit_acc,
  .condition_code_register, .exc_start, .irq_req, .nmi_req, .irq_accept, .nmi_accept, .ui_mask);

// *** tb/tb_crf_core.sv ***
// self-checking bench for the register file block
`timescale 1ns/1ps
`include "crf_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_crf_core;
  typedef struct packed {logic [2:0] op; logic [1:0] sz; logic [31:0] a; logic [31:0] b;
    logic [31:0] r; logic so; logic [4:0] e; logic [4:0] m;} crf_row_t;
  logic clk_sys = 1'h0, rst_n = 1'h0, clk_en = 1'h1, wr_en = 1'h0, wr_upper = 1'h0;
  logic wr_high_byte = 1'h0, sp_wr_en = 1'h0, pc_load = 1'h0, pc_advance = 1'h0;
  logic mode_1mbyte = 1'h0, flag_update = 1'h0, flag_carry_in = 1'h0, flag_shift_out = 1'h0;
  logic bit_acc_wr = 1'h0, bit_acc_value = 1'h0, ccr_op_en = 1'h0, exc_start = 1'h0;
  logic irq_req = 1'h0, nmi_req = 1'h0;
  logic [1:0] wr_size = 2'h0, flag_size = 2'h0, ccr_op = 2'h0;
  logic [2:0] wr_idx = 3'h0, rd_a_idx = 3'h0, rd_b_idx = 3'h0, flag_op = 3'h0;
  logic [3:0] branch_cond = 4'h0;
  logic [7:0] flag_keep = 8'h0, ccr_operand = 8'h0;
  logic [23:0] pc_load_value = 24'h0, vector_value = 24'h0, eff_addr_in = 24'h0;
  logic [31:0] wr_data = 32'h0, sp_wr_data = 32'h0, flag_opa = 32'h0, flag_opb = 32'h0;
  logic [31:0] flag_result = 32'h0;
  wire [31:0] rd_a_data, rd_b_data, stack_pointer_register;
  wire [23:0] pc_value, fetch_addr, eff_addr_out;
  wire [7:0] condition_code_register;
  wire bit_acc, irq_accept, nmi_accept, ui_mask, branch_taken;
  wire [7:0] cc = condition_code_register;
  int err_count = 0, comparisons = 0;
  // flag cases: op, size, a, b, result, shifted-out bit, expected H N Z V C, mask
  crf_row_t rows [11] = '{
    '{3'h1, 2'h0, 32'h0F, 32'h01, 32'h10, 1'h0, 5'h10, 5'h1F},
    '{3'h1, 2'h0, 32'h7F, 32'h01, 32'h80, 1'h0, 5'h1A, 5'h1F},
    '{3'h1, 2'h0, 32'hFF, 32'h01, 32'h00, 1'h0, 5'h15, 5'h1F},
    '{3'h1, 2'h1, 32'h0F00, 32'h0100, 32'h1000, 1'h0, 5'h10, 5'h1F},
    '{3'h1, 2'h1, 32'h00FF, 32'h0001, 32'h0100, 1'h0, 5'h00, 5'h1F},
    '{3'h1, 2'h2, 32'h0F000000, 32'h01000000, 32'h10000000, 1'h0, 5'h10, 5'h1F},
    '{3'h2, 2'h0, 32'h00, 32'h01, 32'hFF, 1'h0, 5'h19, 5'h1F},
    '{3'h2, 2'h2, 32'h80000000, 32'h01, 32'h7FFFFFFF, 1'h0, 5'h12, 5'h1F},
    '{3'h4, 2'h0, 32'h40, 32'h00, 32'h80, 1'h1, 5'h09, 5'h0F},
    '{3'h3, 2'h1, 32'h00, 32'h00, 32'h0000, 1'h0, 5'h04, 5'h0E},
    '{3'h5, 2'h0, 32'h00, 32'h00, 32'h80, 1'h0, 5'h08, 5'h0E}};
  crf_core u_dut (.clk_sys, .rst_n, .clk_en, .wr_en, .wr_idx, .wr_size, .wr_upper,
    .wr_high_byte, .wr_data, .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data,
    .stack_pointer_register, .sp_wr_en, .sp_wr_data, .pc_load, .pc_load_value, .pc_advance,
    .vector_value, .pc_value, .fetch_addr, .mode_1mbyte, .eff_addr_in, .eff_addr_out,
    .flag_update, .flag_op, .flag_size, .flag_opa, .flag_opb, .flag_carry_in,
    .flag_shift_out, .flag_result, .flag_keep, .bit_acc_wr, .bit_acc_value, .bit_acc,
    .ccr_op_en, .ccr_op, .ccr_operand, .condition_code_register, .exc_start, .irq_req,
    .nmi_req, .irq_accept, .nmi_accept, .ui_mask, .branch_cond, .branch_taken);
  // 25 MHz clock
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  task close_out;
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one taken edge, strobes dropped, then settle to the falling edge
  task cyc;
    @(posedge clk_sys);
    {wr_en, sp_wr_en, pc_load, pc_advance, flag_update, bit_acc_wr, ccr_op_en, exc_start} <= 8'h0;
    @(negedge clk_sys);
  endtask
  task wreg(input [2:0] i, input [1:0] s, input u, input h, input [31:0] d);
    @(posedge clk_sys);
    {wr_en, wr_idx, wr_size, wr_upper, wr_high_byte, wr_data} <= {1'h1, i, s, u, h, d};
    cyc;
  endtask
  task flags_do(input [1:0] o, input [7:0] v);
    @(posedge clk_sys);
    {ccr_op_en, ccr_op, ccr_operand} <= {1'h1, o, v};
    cyc;
  endtask
  // walk all branch codes, bit n of x is the expected outcome of code n
  task br(input [15:0] x);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_sys) branch_cond <= 4'(i);
      @(negedge clk_sys);
      `CHK(branch_taken, x[i])
    end
  endtask
  // hang guard
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    close_out;
  end
  initial
  begin
    repeat (8) @(negedge clk_sys);
    `CHK(pc_value, `CRF_PC_RST)
    `CHK(cc[7], 1'h1)
    @(posedge clk_sys) rst_n <= 1'h1;
    foreach (rows[n])
    begin
      @(posedge clk_sys);
      {flag_update, flag_op, flag_size, flag_opa, flag_opb, flag_result, flag_shift_out} <=
        {1'h1, rows[n].op, rows[n].sz, rows[n].a, rows[n].b, rows[n].r, rows[n].so};
      cyc;
      `CHK({cc[5], cc[3:0]} & rows[n].m, rows[n].e)
    end
    // every register long-written, read on both ports
    for (int k = 0; k < 8; k++)
      wreg(3'(k), `CRF_SZ_L, 1'h0, 1'h0, {8{4'(k)}});
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_sys) {rd_a_idx, rd_b_idx} <= {3'(k), 3'(7 - k)};
      @(negedge clk_sys);
      `CHK(rd_a_data, {8{4'(k)}})
      `CHK(rd_b_data, {8{4'(7 - k)}})
    end
    // partial views of register 2 keep the other bits
    @(posedge clk_sys) rd_a_idx <= 3'h2;
    wreg(3'h2, `CRF_SZ_B, 1'h0, 1'h1, 32'hAB);
    `CHK(rd_a_data, 32'h2222AB22)
    wreg(3'h2, `CRF_SZ_W, 1'h1, 1'h0, 32'h5566);
    `CHK(rd_a_data, 32'h5566AB22)
    wreg(3'h2, `CRF_SZ_B, 1'h0, 1'h0, 32'hCD);
    `CHK(rd_a_data, 32'h5566ABCD)
    wreg(3'h2, `CRF_SZ_W, 1'h0, 1'h0, 32'h1234);
    `CHK(rd_a_data, 32'h55661234)
    // implicit stack write beats a plain write to register 7
    @(posedge clk_sys);
    {sp_wr_en, sp_wr_data, wr_en, wr_idx, wr_size} <= {1'h1, 32'h00FFFF00, 1'h1, 3'h7, 2'h2};
    cyc;
    `CHK(stack_pointer_register, 32'h00FFFF00)
    // pc load over advance, then step
    @(posedge clk_sys) {pc_load, pc_load_value, pc_advance} <= {1'h1, 24'h123457, 1'h1};
    cyc;
    `CHK(pc_value, 24'h123457)
    `CHK(fetch_addr, 24'h123456)
    @(posedge clk_sys) pc_advance <= 1'h1;
    cyc;
    `CHK(pc_value, 24'h123459)
    // clock enable low freezes the counter
    @(posedge clk_sys) {clk_en, pc_advance} <= 2'h1;
    cyc;
    `CHK(pc_value, 24'h123459)
    @(posedge clk_sys) clk_en <= 1'h1;
    // whole-register operations
    flags_do(`CRF_CC_LOAD, 8'h00);
    `CHK(cc, 8'h00)
    flags_do(`CRF_CC_OR, 8'h50);
    `CHK(cc, 8'h50)
    flags_do(`CRF_CC_AND, 8'h10);
    `CHK(cc, 8'h10)
    flags_do(`CRF_CC_XOR, 8'h41);
    `CHK(ui_mask, 1'h1)
    // interrupt accept before and after an exception start
    @(posedge clk_sys) {irq_req, nmi_req} <= 2'h3;
    @(negedge clk_sys);
    `CHK({irq_accept, nmi_accept}, 2'h3)
    @(posedge clk_sys) exc_start <= 1'h1;
    cyc;
    `CHK(cc, 8'hD1)
    `CHK({irq_accept, nmi_accept}, 2'h1)
    @(posedge clk_sys) {bit_acc_wr, bit_acc_value} <= 2'h2;
    cyc;
    `CHK(cc, 8'hD0)
    // carry kept while the other flags follow an add
    @(posedge clk_sys);
    {flag_update, flag_op, flag_size, flag_opa, flag_opb, flag_result, flag_keep} <=
      {1'h1, `CRF_OP_ADD, `CRF_SZ_B, 32'hFF, 32'h01, 32'h00, 8'h01};
    cyc;
    `CHK(cc, 8'hF4)
    flags_do(`CRF_CC_LOAD, 8'h04);
    br(16'h9599);
    flags_do(`CRF_CC_LOAD, 8'h0B);
    br(16'h5A69);
    @(posedge clk_sys) {mode_1mbyte, eff_addr_in} <= {1'h1, 24'hABCDEF};
    @(negedge clk_sys);
    `CHK(eff_addr_out, 24'h0BCDEF)
    @(posedge clk_sys) mode_1mbyte <= 1'h0;
    @(negedge clk_sys);
    `CHK(eff_addr_out, 24'hABCDEF)
    // second reset with the mask clear
    @(posedge clk_sys) rst_n <= 1'h0;
    @(negedge clk_sys);
    `CHK(pc_value, `CRF_PC_RST)
    `CHK(cc[7], 1'h1)
    close_out;
  end
endmodule
